// *** hw/first_address_capture_seq_device.sv ***
// Device end: holds ready/wait low through reset, then captures the start address.
`timescale 1ns/100ps
// Functional notes
// - Ready low during reset, released after delay
// - Sequence spans four counted clock edges
// - Address captured on third edge after ready
// - Host starts with latch high, outputs enabled
// - Sequence resets when ready low, mode bit
// - Output enable triggers only after reset
// - Any main-array address accepted as start
// - Gated clock static 5 us after ready
// - Free-run: address valid 200 us early; host drives it from reset release, well under 200 us before ready
// - Free-run: output enable low 200 us early
// - Address held until fourth edge plus margin
// - Host resets device after io supply drop; here the device resets itself while io_supply_ok_i is low
module first_address_capture_seq_device (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic start_mode_cfg_bit_i,
  input wire logic io_supply_ok_i,
  output logic ready_o,
  output logic [first_address_capture_seq_pkg::ADDR_W-1:0] start_addr_o,
  output logic [first_address_capture_seq_pkg::ADDR_W-1:0] read_addr_o,
  input wire logic [first_address_capture_seq_pkg::DATA_W-1:0] rd_data_i,
  first_address_capture_seq_if.device link
);
  first_address_capture_seq_pkg::dev_state_t state_ff, nxt_state;
  logic [7:0] rwl_ff;
  logic [2:0] edge_ff;
  logic armed_ff;
  logic ready_wait_ff;
  logic [first_address_capture_seq_pkg::ADDR_W-1:0] start_ff, read_ff;
  logic [first_address_capture_seq_pkg::DATA_W-1:0] data_ff;
  logic pulse_meta_ff, pulse_ff, oe_meta_ff, oe_n_ff, le_meta_ff, le_ff, ke_meta_ff, ke_ff, sup_meta_ff, sup_ff;
  logic [first_address_capture_seq_pkg::ADDR_W-1:0] addr_meta_ff, addr_ff;

  // Reset in force: the host's pulse (synchronised) or a lost io supply.
  wire hold_reset = !pulse_ff || !sup_ff;
  wire rwl_done = (rwl_ff == 8'h00);
  // Host conditions that allow counting to start.
  wire start_ok = le_ff && pulse_ff && !oe_n_ff && armed_ff;
  wire tick = ke_ff;
  wire capture = (state_ff == first_address_capture_seq_pkg::DEV_COUNT) && tick && (edge_ff == first_address_capture_seq_pkg::CAPTURE_EDGE - 3'h1);
  wire seq_end = (state_ff == first_address_capture_seq_pkg::DEV_COUNT) && tick && (edge_ff == first_address_capture_seq_pkg::SEQ_EDGES - 3'h1);
  wire seq_clear = !ready_wait_ff && start_mode_cfg_bit_i;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      first_address_capture_seq_pkg::DEV_RESET: if (rwl_done) nxt_state = first_address_capture_seq_pkg::DEV_ARMED;
      first_address_capture_seq_pkg::DEV_ARMED: if (start_ok) nxt_state = first_address_capture_seq_pkg::DEV_COUNT;
      first_address_capture_seq_pkg::DEV_COUNT: if (seq_end) nxt_state = first_address_capture_seq_pkg::DEV_BURST;
      first_address_capture_seq_pkg::DEV_BURST: nxt_state = first_address_capture_seq_pkg::DEV_BURST;
    endcase
    if (hold_reset) nxt_state = first_address_capture_seq_pkg::DEV_RESET;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      {pulse_meta_ff, pulse_ff, oe_meta_ff, oe_n_ff} <= 4'h5;
      {le_meta_ff, le_ff, ke_meta_ff, ke_ff, sup_meta_ff, sup_ff} <= 6'h00;
      addr_meta_ff <= first_address_capture_seq_pkg::ADDR_RST;
      addr_ff <= first_address_capture_seq_pkg::ADDR_RST;
    end else begin
      pulse_meta_ff <= link.reset_pulse_n;
      pulse_ff <= pulse_meta_ff;
      oe_meta_ff <= link.out_en_n;
      oe_n_ff <= oe_meta_ff;
      le_meta_ff <= link.addr_latch_en;
      le_ff <= le_meta_ff;
      ke_meta_ff <= link.link_clk_en;
      ke_ff <= ke_meta_ff;
      sup_meta_ff <= io_supply_ok_i;
      sup_ff <= sup_meta_ff;
      addr_meta_ff <= link.addr;
      addr_ff <= addr_meta_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_ff <= first_address_capture_seq_pkg::DEV_RESET;
      rwl_ff <= 8'(first_address_capture_seq_pkg::RWL_CYC);
      edge_ff <= 3'h0;
      armed_ff <= 1'b0;
      ready_wait_ff <= 1'b0;
      start_ff <= first_address_capture_seq_pkg::ADDR_RST;
      read_ff <= first_address_capture_seq_pkg::ADDR_RST;
      data_ff <= first_address_capture_seq_pkg::DATA_RST;
    end else begin
      state_ff <= nxt_state;
      if (hold_reset) begin
        rwl_ff <= 8'(first_address_capture_seq_pkg::RWL_CYC);
        armed_ff <= 1'b1;
        ready_wait_ff <= 1'b0;
      end else begin
        if (!rwl_done) rwl_ff <= rwl_ff - 8'h01;
        if (rwl_done) ready_wait_ff <= 1'b1;
        // Arming is spent once counting begins; only a reset restores it.
        if (state_ff == first_address_capture_seq_pkg::DEV_ARMED && start_ok) armed_ff <= 1'b0;
      end
      if (seq_clear || state_ff != first_address_capture_seq_pkg::DEV_COUNT) edge_ff <= 3'h0;
      else if (tick) edge_ff <= edge_ff + 3'h1;
      if (capture) start_ff <= addr_ff;
      if (capture) read_ff <= addr_ff;
      else if (state_ff == first_address_capture_seq_pkg::DEV_BURST && tick) read_ff <= read_ff + 1'b1;
      if (state_ff == first_address_capture_seq_pkg::DEV_BURST && tick) data_ff <= rd_data_i;
    end
  end

  assign link.ready_wait = ready_wait_ff;
  assign link.data = data_ff;
  assign ready_o = ready_wait_ff;
  assign start_addr_o = start_ff;
  assign read_addr_o = read_ff;
endmodule

// *** hw/first_address_capture_seq_host.sv ***
// Host end: drives the start-up pins and counts the capture edges.
`timescale 1ns/100ps
module first_address_capture_seq_host (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  input wire logic free_run_i,
  input wire logic [first_address_capture_seq_pkg::ADDR_W-1:0] start_addr_i,
  output logic busy_o,
  output logic word_valid_o,
  output logic [first_address_capture_seq_pkg::DATA_W-1:0] word_o,
  first_address_capture_seq_if.host link
);
  first_address_capture_seq_pkg::host_state_t state_ff, nxt_state;
  logic [15:0] wait_ff;
  logic [2:0] edge_ff;
  logic [first_address_capture_seq_pkg::ADDR_W-1:0] addr_ff;
  logic ready_meta_ff, ready_ff;
  logic [first_address_capture_seq_pkg::DATA_W-1:0] word_ff;
  logic valid_ff;
  // Words reach this end two synchroniser stages and one device register after the counted edge.
  logic [1:0] read_dly_ff;
  wire wait_done = (wait_ff == 16'h0000);
  wire in_setup = (state_ff == first_address_capture_seq_pkg::HST_SETUP);
  wire in_edges = (state_ff == first_address_capture_seq_pkg::HST_EDGES);
  wire in_read = (state_ff == first_address_capture_seq_pkg::HST_READ);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      first_address_capture_seq_pkg::HST_SETUP: if (start_i) nxt_state = first_address_capture_seq_pkg::HST_WAIT;
      first_address_capture_seq_pkg::HST_WAIT: if (ready_ff && wait_done) nxt_state = first_address_capture_seq_pkg::HST_EDGES;
      first_address_capture_seq_pkg::HST_EDGES: if (edge_ff == first_address_capture_seq_pkg::SEQ_EDGES) nxt_state = first_address_capture_seq_pkg::HST_READ;
      first_address_capture_seq_pkg::HST_READ: nxt_state = first_address_capture_seq_pkg::HST_READ;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_ff <= first_address_capture_seq_pkg::HST_SETUP;
      wait_ff <= 16'h0000;
      edge_ff <= 3'h0;
      addr_ff <= first_address_capture_seq_pkg::ADDR_RST;
      ready_meta_ff <= 1'b0;
      ready_ff <= 1'b0;
      word_ff <= first_address_capture_seq_pkg::DATA_RST;
      valid_ff <= 1'b0;
      read_dly_ff <= 2'h0;
    end else begin
      ready_meta_ff <= link.ready_wait;
      ready_ff <= ready_meta_ff;
      state_ff <= nxt_state;
      if (in_setup) begin
        addr_ff <= start_addr_i;
        wait_ff <= free_run_i ? 16'(first_address_capture_seq_pkg::AVRWH_CYC) : 16'(first_address_capture_seq_pkg::RWHK_CYC);
      end else if (!ready_ff) begin
        wait_ff <= free_run_i ? 16'(first_address_capture_seq_pkg::AVRWH_CYC) : 16'(first_address_capture_seq_pkg::RWHK_CYC);
      end else if (!wait_done) begin
        wait_ff <= wait_ff - 16'h0001;
      end
      if (in_edges) edge_ff <= edge_ff + 3'h1;
      read_dly_ff <= {read_dly_ff[0], in_read};
      valid_ff <= read_dly_ff[1];
      if (read_dly_ff[1]) word_ff <= link.data;
    end
  end

  // Edges are passed one per cycle once the static hold has run out, or from the end of setup when free_run_i is set.
  assign link.link_clk_en = in_edges || in_read || (free_run_i && !in_setup);
  assign link.addr = addr_ff;
  assign link.addr_latch_en = 1'b1;
  assign link.reset_pulse_n = !sys_rst_i;
  assign link.out_en_n = 1'b0;
  assign busy_o = !in_read;
  assign word_valid_o = valid_ff;
  assign word_o = word_ff;
endmodule

// *** include/first_address_capture_seq_if.sv ***
// Link between the storage device and its configuration host.
`timescale 1ns/100ps
interface first_address_capture_seq_if;
  logic link_clk_en;
  logic [first_address_capture_seq_pkg::ADDR_W-1:0] addr;
  logic addr_latch_en;
  logic reset_pulse_n;
  logic out_en_n;
  logic ready_wait;
  logic [first_address_capture_seq_pkg::DATA_W-1:0] data;
  modport device (
    input link_clk_en, addr, addr_latch_en, reset_pulse_n, out_en_n,
    output ready_wait, data
  );
  modport host (
    output link_clk_en, addr, addr_latch_en, reset_pulse_n, out_en_n,
    input ready_wait, data
  );
endinterface

// *** include/first_address_capture_seq_pkg.sv ***
// Shared constants and types for the first-address capture link.
package first_address_capture_seq_pkg;
  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;
  localparam int CLK_MHZ = 250;
  // Ready/wait low time after reset release, in ns.
  localparam int RWL_NS = 100;
  localparam int RWL_CYC = (RWL_NS * CLK_MHZ + 999) / 1000;
  // Host keeps link clock static this long after ready rises, in us.
  localparam int RWHK_US = 5;
  localparam int RWHK_CYC = RWHK_US * CLK_MHZ;
  // Address valid and output enable low before ready rises, in us.
  localparam int AVRWH_US = 200;
  localparam int AVRWH_CYC = AVRWH_US * CLK_MHZ;
  // Counted edges: capture on the third, sequence ends on the fourth.
  localparam logic [2:0] CAPTURE_EDGE = 3'h3;
  localparam logic [2:0] SEQ_EDGES = 3'h4;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 23'h000000;
  typedef enum logic [3:0] {
    DEV_RESET = 4'h1,
    DEV_ARMED = 4'h2,
    DEV_COUNT = 4'h4,
    DEV_BURST = 4'h8
  } dev_state_t;
  typedef enum logic [3:0] {
    HST_SETUP = 4'h1,
    HST_WAIT = 4'h2,
    HST_EDGES = 4'h4,
    HST_READ = 4'h8
  } host_state_t;
endpackage

// *** verification/first_address_capture_seq_asserts.sv ***
// Link checks between the host and device ends.
`timescale 1ns/100ps
module first_address_capture_seq_asserts (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic link_clk_en,
  input wire logic [22:0] addr,
  input wire logic addr_latch_en,
  input wire logic reset_pulse_n,
  input wire logic out_en_n,
  input wire logic ready_wait,
  input wire logic [15:0] data
);
  logic [7:0] low_ff;
  logic [15:0] quiet_ff;
  logic [2:0] edges_ff;
  // Counters saturate so a long burst never wraps them back into range.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      low_ff <= 8'h00;
      quiet_ff <= 16'h0000;
      edges_ff <= 3'h0;
    end else begin
      low_ff <= ready_wait ? 8'h00 : low_ff + 8'(low_ff != 8'hFF);
      quiet_ff <= !ready_wait ? 16'h0000 : quiet_ff + 16'(quiet_ff != 16'hFFFF);
      edges_ff <= !ready_wait ? 3'h0 : edges_ff + 3'(link_clk_en && edges_ff != 3'h7);
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_rise; !ready_wait ##1 ready_wait; endsequence
  property p_rst; $fell(sys_rst_i) |-> !ready_wait; endproperty
  a_rst: assert property (p_rst) else $error("ready high after reset");
  property p_low; s_rise |-> low_ff >= 8'(first_address_capture_seq_pkg::RWL_CYC); endproperty
  a_low: assert property (p_low) else $error("ready low too short");
  property p_pins; ready_wait |-> addr_latch_en && reset_pulse_n && !out_en_n; endproperty
  a_pins: assert property (p_pins) else $error("start pins wrong");
  property p_pre; s_rise |-> $past(addr_latch_en && !out_en_n); endproperty
  a_pre: assert property (p_pre) else $error("pins late");
  property p_quiet; ready_wait && link_clk_en |-> quiet_ff >= 16'(first_address_capture_seq_pkg::RWHK_CYC); endproperty
  a_quiet: assert property (p_quiet) else $error("clock too early");
  property p_nodata; ready_wait && edges_ff < 3'h4 |-> data == first_address_capture_seq_pkg::DATA_RST; endproperty
  a_nodata: assert property (p_nodata) else $error("data before sequence end");
  property p_hold; ready_wait && edges_ff < 3'h4 |=> $stable(addr) || !ready_wait; endproperty
  a_hold: assert property (p_hold) else $error("address moved");
  property p_step; ready_wait && $changed(data) |-> $past(link_clk_en, 2) || $past(link_clk_en, 3); endproperty
  a_step: assert property (p_step) else $error("word without edge");
endmodule

// *** verification/tb_first_address_latch_sequencer.sv ***
// Bench joining both ends of the start-address link.
`timescale 1ns/100ps
module tb_first_address_latch_sequencer;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic go = 1'b0;
  logic cfg = 1'b0;
  logic sup = 1'b1;
  logic [22:0] sa = 23'h000000;
  logic rdy;
  logic vld;
  logic [22:0] cap;
  logic [22:0] ra;
  logic [15:0] wd;
  logic [15:0] q[$];
  logic [31:0] r;
  int n_fail = 0;
  int comparisons = 0;
  int k;
  first_address_capture_seq_if link();
  always #2 clk_i = ~clk_i;
  // Array words scramble the address, so a wrong start or step shows.
  function automatic logic [15:0] w(input logic [22:0] a);
    return a[15:0] ^ {9'h000, a[22:16]} ^ 16'hA5C3;
  endfunction
  first_address_capture_seq_device first_address_capture_seq_device_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .start_mode_cfg_bit_i(cfg),
    .io_supply_ok_i(sup), .ready_o(rdy), .start_addr_o(cap), .read_addr_o(ra), .rd_data_i(w(ra)), .link(link));
  first_address_capture_seq_host first_address_capture_seq_host_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .start_i(go), .free_run_i(1'b0),
    .start_addr_i(sa), .busy_o(), .word_valid_o(vld), .word_o(wd), .link(link));
  first_address_capture_seq_asserts first_address_capture_seq_asserts_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .link_clk_en(link.link_clk_en),
    .addr(link.addr), .addr_latch_en(link.addr_latch_en), .reset_pulse_n(link.reset_pulse_n),
    .out_en_n(link.out_en_n), .ready_wait(link.ready_wait), .data(link.data));
  task automatic check(input logic [31:0] seen, input logic [31:0] expd);
    comparisons++;
    if (seen !== expd) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask
  task automatic final_report();
    if (n_fail == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(negedge clk_i) begin
    if (vld === 1'b1 && q.size() > 0) check(wd, q.pop_front());
  end
  task automatic run(input logic [22:0] a);
    sys_rst_i <= 1'b1;
    sup <= 1'b1;
    repeat (5) @(posedge clk_i);
    sa <= a;
    cfg <= r[0];
    sys_rst_i <= 1'b0;
    go <= 1'b1;
    for (k = 0; k < 6; k++) q.push_back(w(a + 23'(k)));
    k = 0;
    while (q.size() > 0 && k < 3000) begin
      @(posedge clk_i);
      k++;
    end
    check(q.size(), 0);
    check(cap, a);
    check(rdy, 1'b1);
  endtask
  initial begin
    r = $urandom(32'hDBCC);
    run(23'h000000);
    run(23'h7FFFFD);
    repeat (3) begin
      r = $urandom;
      run(r[30:8]);
    end
    sup <= 1'b0;
    repeat (8) @(posedge clk_i);
    check(rdy, 1'b0);
    run(23'h2AAAAA);
    final_report();
  end
  initial begin
    #200000;
    n_fail++;
    final_report();
  end
endmodule
